// File: rtu_pkg.sv
// constants, types and crc helper for the rtu slave message handler
package rtu_pkg;
  localparam logic [7:0] RTU_OP_RD_COIL = 8'h01;
  localparam logic [7:0] RTU_OP_RD_REGS = 8'h03;
  localparam logic [7:0] RTU_OP_WR_ONE = 8'h06;
  localparam logic [7:0] RTU_OP_DIAG = 8'h08;
  localparam logic [7:0] RTU_OP_WR_MULTI = 8'h10;
  localparam logic [7:0] RTU_OP_EXC_FLAG = 8'h80;
  localparam logic [7:0] RTU_EXC_BAD_OP = 8'h01;
  localparam logic [7:0] RTU_EXC_BAD_ADDR = 8'h02;
  localparam logic [7:0] RTU_EXC_BAD_DATA = 8'h03;
  localparam logic [7:0] RTU_EXC_NONE = 8'h00;
  localparam logic [7:0] RTU_BCAST_ADDR = 8'h00;
  localparam logic [15:0] RTU_MIN_WORDS = 16'h0001;
  localparam logic [15:0] RTU_MAX_WORDS = 16'h0032;
  localparam logic [15:0] RTU_DIAG_SUB = 16'h0000;
  localparam logic [8:0] RTU_PARAM_LAST = 9'h063;
  localparam logic [10:0] RTU_PARAM_PER_GRP = 11'h064;
  localparam logic [7:0] RTU_GRP_LOW_LAST = 8'h08;
  localparam logic [7:0] RTU_GRP_HIGH_FIRST = 8'h0d;
  localparam logic [7:0] RTU_GRP_HIGH_LAST = 8'h11;
  localparam logic [7:0] RTU_GRP_GAP = 8'h04;
  localparam int RTU_MEM_WORDS = 1400;
  localparam logic [15:0] RTU_NUM_COILS = 16'h0050;
  localparam int RTU_COIL_W = 80;
  localparam logic [7:0] RTU_FIXED_LEN = 8'h08;
  localparam logic [8:0] RTU_MULTI_HDR_LEN = 9'h009;
  localparam logic [7:0] RTU_ECHO_LEN = 8'h06;
  localparam logic [7:0] RTU_RSP_HDR_LEN = 8'h03;
  localparam logic [7:0] RTU_MIN_FRAME = 8'h04;
  localparam int RTU_BUF_DEPTH = 128;
  localparam logic [7:0] RTU_BUF_LAST = 8'h7f;
  localparam logic [15:0] RTU_CRC_INIT = 16'hffff;
  localparam logic [15:0] RTU_CRC_POLY = 16'ha001;
  localparam logic [3:0] RTU_REG_CTRL = 4'h0;
  localparam logic [3:0] RTU_REG_STATUS = 4'h4;
  localparam logic [3:0] RTU_REG_DROPS = 4'h8;
  localparam int RTU_CTRL_EN_BIT = 8;
  localparam logic [15:0] RTU_CTRL_RST = 16'h0101;

  typedef enum logic [2:0] {
    ST_RX, ST_CHECK, ST_WRITE, ST_LOAD, ST_SEND
  } rtu_state_e;
  typedef enum logic [1:0] {RK_ERR, RK_ECHO, RK_READ, RK_COIL} rtu_kind_e;

  // one byte of the reflected crc-16, lsb first
  function automatic logic [15:0] rtu_crc_byte(input logic [15:0] crc,
                                               input logic [7:0] d);
    logic [15:0] c;
    c = crc ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ RTU_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage

// File: rtu_slave_handler.sv
// rtu slave message handler: query decode, parameter store, responses
// What this block does
// RULE1 - read registers to broadcast gets no answer
// RULE2 - parameter code: group high, number 0-99 low
// RULE3 - valid groups 00h-08h and 0Dh-11h only
// RULE4 - register read asks at most 50 words
// RULE5 - undefined parameter reads as zero, no error; a read in groups 09h-0Ch or above 11h gets the bad address error
// RULE6 - read stops at group end, rest zero
// RULE7 - read byte count is twice word count
// RULE8 - read words high byte first, ascending numbers
// RULE9 - single write broadcast executes, never answered
// RULE10 - single write stores word, echoes the query
// RULE11 - multiple write broadcast executes, never answered
// RULE12 - write word count 1-50, else error
// RULE13 - host byte count is twice word count
// RULE14 - host sends words ascending, high byte first
// RULE15 - writes to undefined parameters dropped silently; a single write to one, or a multiple write to a missing group, gets the bad address error
// RULE16 - multiple write answer echoes code and count
// RULE17 - diagnostics to broadcast gets no answer
// RULE18 - diagnostics sub operation must be zero
// RULE19 - diagnostics answer echoes the whole query
// RULE20 - coil read: address, count, 1-10 data bytes
// RULE21 - every frame ends with crc-16
// RULE22 - crc or character error: discard, no answer
// RULE23 - station 0-247, zero means broadcast
// RULE24 - only own address or broadcast is served
// RULE25 - unknown op code answered with msb set
`timescale 1ns/10ps
`default_nettype none
module rtu_slave_handler
  import rtu_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic ARST_N_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_VALID_I,
  input wire logic RX_ERR_I,
  input wire logic RX_END_I,
  output logic [7:0] TX_DATA_O,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  input wire logic [79:0] COIL_STATE_I,
  output logic PARAM_WE_O,
  output logic [15:0] PARAM_CODE_O,
  output logic [15:0] PARAM_DATA_O,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O
);
  // rx inputs come from the character receiver on this clock: no synchroniser
  logic [7:0] rx_buf [RTU_BUF_DEPTH];
  logic [15:0] param_mem [RTU_MEM_WORDS];
  rtu_state_e state_reg;
  rtu_kind_e kind_reg;
  logic [7:0] rx_len_reg;
  logic [15:0] rx_crc_reg;
  logic rx_bad_reg;
  logic bcast_reg;
  logic [7:0] tx_len_reg;
  logic [7:0] tx_pos_reg;
  logic [15:0] tx_crc_reg;
  logic [7:0] tx_data_reg;
  logic [5:0] wr_idx_reg;
  logic [7:0] exc_reg;
  logic [7:0] last_exc_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] drops_reg;
  logic [15:0] rdata_reg;
  logic [7:0] chk_exc;
  logic chk_silent;
  logic [7:0] pick;

  wire [7:0] station = rx_buf[0];
  wire [7:0] op = rx_buf[1];
  wire [7:0] grp = rx_buf[2];
  wire [7:0] num = rx_buf[3];
  wire [15:0] field2 = {rx_buf[2], rx_buf[3]};
  wire [15:0] field4 = {rx_buf[4], rx_buf[5]};
  wire [7:0] bcnt = rx_buf[6];
  wire [7:0] own_addr = ctrl_reg[7:0];
  wire enabled = ctrl_reg[RTU_CTRL_EN_BIT];

  // group code to dense store index; codes 09h-0Ch and above 11h are absent
  wire grp_low = (grp <= RTU_GRP_LOW_LAST); // RULE3
  wire grp_ok = grp_low || (grp >= RTU_GRP_HIGH_FIRST && // RULE3
                grp <= RTU_GRP_HIGH_LAST);
  wire [7:0] grp_sub = grp - RTU_GRP_GAP;
  wire [3:0] grp_idx = grp_low ? grp[3:0] : grp_sub[3:0];
  wire [21:0] grp_prod = {7'h00, grp_idx} * RTU_PARAM_PER_GRP; // RULE2
  wire [10:0] grp_base = grp_prod[10:0];
  wire num_ok = ({1'b0, num} <= RTU_PARAM_LAST); // RULE2

  wire is_bc = (station == RTU_BCAST_ADDR); // RULE23
  wire addressed = enabled && (station == own_addr || is_bc); // RULE24
  wire supported = (op == RTU_OP_RD_COIL) || (op == RTU_OP_RD_REGS) ||
                   (op == RTU_OP_WR_ONE) || (op == RTU_OP_DIAG) ||
                   (op == RTU_OP_WR_MULTI);
  // frame length follows from op code and byte count
  wire [8:0] exp_len = (op == RTU_OP_WR_MULTI) ? // RULE21
                       (RTU_MULTI_HDR_LEN + {1'b0, bcnt}) :
                       {1'b0, RTU_FIXED_LEN};
  wire len_ok = !supported || ({1'b0, rx_len_reg} == exp_len);
  // running crc over data and check field leaves zero on a clean frame
  wire frame_ok = !rx_bad_reg && (rx_len_reg >= RTU_MIN_FRAME) && // RULE22
                  (rx_crc_reg == 16'h0000) && len_ok;
  wire cnt_ok = (field4 >= RTU_MIN_WORDS) && (field4 <= RTU_MAX_WORDS);
  wire [7:0] twice_cnt = {field4[6:0], 1'b0};
  wire drop = !frame_ok || !addressed || chk_silent ||
              (is_bc && chk_exc != RTU_EXC_NONE);

  always_comb begin
    chk_exc = RTU_EXC_NONE;
    chk_silent = 1'b0;
    case (op)
      RTU_OP_RD_REGS: begin
        if (is_bc) begin
          chk_silent = 1'b1; // RULE1
        end else if (!cnt_ok) begin
          chk_exc = RTU_EXC_BAD_DATA; // RULE4
        end else if (!grp_ok) begin
          chk_exc = RTU_EXC_BAD_ADDR;
        end
      end
      RTU_OP_WR_ONE: begin
        if (!grp_ok || !num_ok) begin
          chk_exc = RTU_EXC_BAD_ADDR;
        end
      end
      RTU_OP_WR_MULTI: begin
        if (!cnt_ok || bcnt != twice_cnt) begin
          chk_exc = RTU_EXC_BAD_DATA; // RULE12 RULE13
        end else if (!grp_ok) begin
          chk_exc = RTU_EXC_BAD_ADDR;
        end
      end
      RTU_OP_DIAG: begin
        if (is_bc) begin
          chk_silent = 1'b1; // RULE17
        end else if (field2 != RTU_DIAG_SUB) begin
          chk_exc = RTU_EXC_BAD_DATA; // RULE18
        end
      end
      RTU_OP_RD_COIL: begin
        if (is_bc) begin
          chk_silent = 1'b1;
        end else if (field2 >= RTU_NUM_COILS || field4 == 16'h0000 ||
                     field4 > RTU_NUM_COILS) begin
          chk_exc = RTU_EXC_BAD_ADDR; // RULE20
        end
      end
      default: begin
        chk_exc = RTU_EXC_BAD_OP; // RULE25
      end
    endcase
  end

  // read side: word k of the answer is parameter num+k of the same group
  wire [7:0] rel = tx_pos_reg - RTU_RSP_HDR_LEN;
  wire [8:0] rd_num = {1'b0, num} + {2'b00, rel[7:1]}; // RULE8
  wire rd_def = grp_ok && (rd_num <= RTU_PARAM_LAST); // RULE5 RULE6
  wire [10:0] rd_idx = grp_base + {2'b00, rd_num};
  wire [15:0] rd_word = rd_def ? param_mem[rd_idx] : 16'h0000; // RULE5

  // write side: single write uses the query word, multiple write walks
  wire [7:0] wr_off = {1'b0, wr_idx_reg, 1'b0} + 8'h07;
  wire [7:0] wr_off_lo = wr_off + 8'h01;
  wire [15:0] wr_multi_word = {rx_buf[wr_off[6:0]], // RULE14
                               rx_buf[wr_off_lo[6:0]]};
  wire in_single = (state_reg == ST_CHECK) && !drop &&
                   (chk_exc == RTU_EXC_NONE) && (op == RTU_OP_WR_ONE);
  wire in_multi = (state_reg == ST_WRITE);
  wire [8:0] wr_num = {1'b0, num} + (in_multi ? {3'b000, wr_idx_reg} : 9'h000);
  wire wr_def = grp_ok && (wr_num <= RTU_PARAM_LAST);
  wire [10:0] wr_mem_idx = grp_base + {2'b00, wr_num};
  wire [15:0] wr_word = in_multi ? wr_multi_word : field4;
  wire wr_en = (in_single || in_multi) && wr_def; // RULE15
  wire wr_last = ({10'h000, wr_idx_reg} == field4 - 16'h0001);

  // coil answer: window starts at coil address, bits past the count are 0
  wire [79:0] coil_mask = ~({RTU_COIL_W{1'b1}} << field4[6:0]);
  wire [79:0] coil_vec = (COIL_STATE_I >> field2[6:0]) & coil_mask;
  wire [79:0] coil_win = coil_vec >> {rel[3:0], 3'b000};
  wire [7:0] coil_cnt7 = {1'b0, field4[6:0]} + 8'h07;
  wire [7:0] coil_bytes = {3'b000, coil_cnt7[7:3]}; // RULE20

  wire [7:0] crc_pos = tx_len_reg;
  wire [7:0] crc_pos_hi = tx_len_reg + 8'h01;
  wire tx_fire = (state_reg == ST_SEND) && TX_READY_I;
  wire tx_end = tx_fire && (tx_pos_reg == crc_pos_hi);

  always_comb begin
    pick = 8'h00;
    case (kind_reg)
      RK_ERR: begin
        if (tx_pos_reg == 8'h00) begin
          pick = station;
        end else if (tx_pos_reg == 8'h01) begin
          pick = op | RTU_OP_EXC_FLAG; // RULE25
        end else begin
          pick = exc_reg;
        end
      end
      RK_ECHO: begin
        pick = rx_buf[tx_pos_reg[6:0]]; // RULE10 RULE16 RULE19
      end
      RK_READ: begin
        if (tx_pos_reg < 8'h02) begin
          pick = rx_buf[tx_pos_reg[6:0]];
        end else if (tx_pos_reg == 8'h02) begin
          pick = twice_cnt; // RULE7
        end else begin
          pick = rel[0] ? rd_word[7:0] : rd_word[15:8]; // RULE8
        end
      end
      RK_COIL: begin
        if (tx_pos_reg < 8'h02) begin
          pick = rx_buf[tx_pos_reg[6:0]];
        end else if (tx_pos_reg == 8'h02) begin
          pick = coil_bytes;
        end else begin
          pick = coil_win[7:0];
        end
      end
      default: begin
        pick = 8'h00;
      end
    endcase
    // check field goes low byte first
    if (tx_pos_reg == crc_pos) begin
      pick = tx_crc_reg[7:0]; // RULE21
    end else if (tx_pos_reg == crc_pos_hi) begin
      pick = tx_crc_reg[15:8];
    end
  end

  wire [7:0] read_len = RTU_RSP_HDR_LEN + twice_cnt;
  wire [7:0] coil_len = RTU_RSP_HDR_LEN + coil_bytes;
  wire rx_take = (state_reg == ST_RX) && RX_VALID_I;

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= ST_RX;
      kind_reg <= RK_ERR;
      bcast_reg <= 1'b0;
      tx_len_reg <= 8'h00;
      exc_reg <= RTU_EXC_NONE;
      wr_idx_reg <= 6'h00;
    end else begin
      case (state_reg)
        ST_RX: begin
          bcast_reg <= 1'b0;
          if (RX_END_I) begin
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          bcast_reg <= is_bc;
          exc_reg <= chk_exc;
          wr_idx_reg <= 6'h00;
          tx_len_reg <= RTU_ECHO_LEN;
          kind_reg <= RK_ECHO;
          if (drop) begin
            state_reg <= ST_RX; // RULE22 RULE24
          end else if (chk_exc != RTU_EXC_NONE) begin
            kind_reg <= RK_ERR;
            tx_len_reg <= RTU_RSP_HDR_LEN;
            state_reg <= ST_LOAD;
          end else if (op == RTU_OP_WR_MULTI) begin
            state_reg <= ST_WRITE;
          end else if (op == RTU_OP_WR_ONE) begin
            state_reg <= is_bc ? ST_RX : ST_LOAD; // RULE9
          end else if (op == RTU_OP_RD_REGS) begin
            kind_reg <= RK_READ;
            tx_len_reg <= read_len;
            state_reg <= ST_LOAD;
          end else if (op == RTU_OP_RD_COIL) begin
            kind_reg <= RK_COIL;
            tx_len_reg <= coil_len;
            state_reg <= ST_LOAD;
          end else begin
            state_reg <= ST_LOAD;
          end
        end
        ST_WRITE: begin
          wr_idx_reg <= wr_idx_reg + 6'h01;
          if (wr_last) begin
            state_reg <= bcast_reg ? ST_RX : ST_LOAD; // RULE11
          end
        end
        ST_LOAD: begin
          state_reg <= ST_SEND;
        end
        ST_SEND: begin
          if (tx_end) begin
            state_reg <= ST_RX;
          end else if (tx_fire) begin
            state_reg <= ST_LOAD;
          end
        end
        default: begin
          state_reg <= ST_RX;
        end
      endcase
    end
  end

  // receive capture; bytes arriving while an answer is in work are ignored
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rx_len_reg <= 8'h00;
      rx_crc_reg <= RTU_CRC_INIT;
      rx_bad_reg <= 1'b0;
    end else if (state_reg == ST_CHECK) begin
      rx_len_reg <= 8'h00;
      rx_crc_reg <= RTU_CRC_INIT;
      rx_bad_reg <= 1'b0;
    end else if (state_reg == ST_RX) begin
      if (RX_ERR_I || (rx_take && rx_len_reg > RTU_BUF_LAST)) begin
        rx_bad_reg <= 1'b1; // RULE22
      end
      if (rx_take && rx_len_reg <= RTU_BUF_LAST) begin
        rx_len_reg <= rx_len_reg + 8'h01;
        rx_crc_reg <= rtu_crc_byte(rx_crc_reg, RX_DATA_I); // RULE21
      end
    end
  end

  // buffer is not rewritten before the answer is out, so no reset needed
  always_ff @(posedge CORE_CLK_I) begin
    if (rx_take && rx_len_reg <= RTU_BUF_LAST) begin
      rx_buf[rx_len_reg[6:0]] <= RX_DATA_I;
    end
    if (wr_en) begin
      param_mem[wr_mem_idx] <= wr_word; // RULE10 RULE15
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tx_pos_reg <= 8'h00;
      tx_crc_reg <= RTU_CRC_INIT;
      tx_data_reg <= 8'h00;
    end else if (state_reg == ST_CHECK) begin
      tx_pos_reg <= 8'h00;
      tx_crc_reg <= RTU_CRC_INIT;
    end else if (state_reg == ST_LOAD) begin
      tx_data_reg <= pick;
    end else if (tx_fire) begin
      tx_pos_reg <= tx_pos_reg + 8'h01;
      if (tx_pos_reg < crc_pos) begin
        tx_crc_reg <= rtu_crc_byte(tx_crc_reg, tx_data_reg); // RULE21
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PARAM_WE_O <= 1'b0;
      PARAM_CODE_O <= 16'h0000;
      PARAM_DATA_O <= 16'h0000;
    end else begin
      PARAM_WE_O <= wr_en;
      if (wr_en) begin
        PARAM_CODE_O <= {grp, wr_num[7:0]};
        PARAM_DATA_O <= wr_word;
      end
    end
  end

  assign TX_VALID_O = (state_reg == ST_SEND);
  assign TX_DATA_O = tx_data_reg;

  // control and status registers
  wire reg_sel_ctrl = (REG_ADDR_I == RTU_REG_CTRL);
  wire reg_sel_stat = (REG_ADDR_I == RTU_REG_STATUS);
  wire reg_sel_drop = (REG_ADDR_I == RTU_REG_DROPS);
  wire busy = (state_reg != ST_RX);
  wire [15:0] reg_rd_mux = reg_sel_ctrl ? ctrl_reg :
                           reg_sel_stat ? {7'h00, busy, last_exc_reg} :
                           reg_sel_drop ? drops_reg : 16'h0000;
  wire drop_now = (state_reg == ST_CHECK) && drop;

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_reg <= RTU_CTRL_RST;
      drops_reg <= 16'h0000;
      last_exc_reg <= RTU_EXC_NONE;
      rdata_reg <= 16'h0000;
    end else begin
      if (REG_WR_I && reg_sel_ctrl) begin
        ctrl_reg <= REG_WDATA_I;
      end
      // a write to the drop counter clears it, a drop in that cycle wins
      if (drop_now) begin
        drops_reg <= drops_reg + 16'h0001;
      end else if (REG_WR_I && reg_sel_drop) begin
        drops_reg <= 16'h0000;
      end
      if (state_reg == ST_CHECK && !drop && chk_exc != RTU_EXC_NONE) begin
        last_exc_reg <= chk_exc;
      end
      rdata_reg <= REG_RD_I ? reg_rd_mux : 16'h0000;
    end
  end
  assign REG_RDATA_O = rdata_reg;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  no_bcast_tx_a: assert property ( // RULE9
    TX_VALID_O |-> !bcast_reg) else $error("answer to a broadcast");
  read_bcast_a: assert property ( // RULE1
    (state_reg == ST_CHECK && op == RTU_OP_RD_REGS && is_bc)
    |=> state_reg == ST_RX [*2]) else $error("broadcast read answered");
  read_count_a: assert property ( // RULE7
    (TX_VALID_O && kind_reg == RK_READ && tx_pos_reg == 8'h02)
    |-> TX_DATA_O == twice_cnt) else $error("read byte count wrong");
  read_zero_a: assert property ( // RULE6
    (state_reg == ST_LOAD && kind_reg == RK_READ && tx_pos_reg > 8'h02 &&
     tx_pos_reg < crc_pos && !rd_def) |=> TX_DATA_O == 8'h00)
    else $error("undefined word not zero");
  crc_drop_a: assert property ( // RULE22
    (state_reg == ST_CHECK && !frame_ok) |=> !TX_VALID_O [*3])
    else $error("bad frame answered");
  exc_flag_a: assert property ( // RULE25
    (TX_VALID_O && kind_reg == RK_ERR && tx_pos_reg == 8'h01)
    |-> TX_DATA_O[7]) else $error("error op code msb clear");
  single_wr_a: assert property ( // RULE10
    in_single |=> PARAM_WE_O && PARAM_DATA_O == $past(field4))
    else $error("single write not stored");
  multi_cnt_a: assert property ( // RULE12
    (state_reg == ST_CHECK && frame_ok && addressed && !is_bc &&
     op == RTU_OP_WR_MULTI && field4 > RTU_MAX_WORDS)
    |=> kind_reg == RK_ERR && state_reg == ST_LOAD)
    else $error("word count over limit accepted");
  diag_sub_a: assert property ( // RULE18
    (state_reg == ST_CHECK && frame_ok && addressed && !is_bc &&
     op == RTU_OP_DIAG && field2 != RTU_DIAG_SUB)
    |=> exc_reg == RTU_EXC_BAD_DATA ##1 state_reg == ST_SEND)
    else $error("bad diagnostics sub op accepted");
  echo_byte_a: assert property ( // RULE19
    (TX_VALID_O && kind_reg == RK_ECHO && tx_pos_reg < RTU_ECHO_LEN)
    |-> TX_DATA_O == rx_buf[tx_pos_reg[6:0]])
    else $error("echo byte differs from query");
  foreign_a: assert property ( // RULE24
    (state_reg == ST_CHECK && !is_bc && station != own_addr)
    |=> state_reg == ST_RX) else $error("foreign station served");
endmodule
`default_nettype wire

// File: rtu_host_model.sv
// host master model: frames queries with a check field, gathers answers
`timescale 1ns/10ps
`default_nettype none
module rtu_host_model (
  input wire logic clk_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_err_o,
  output logic rx_end_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  logic [7:0] rsp[$];
  logic crc_ok = 1'b0;
  bit slow = 1'b0;
  int tick = 0;
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_err_o = 1'b0;
    rx_end_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  // slow mode keeps ready off two cycles in three to stall the answer
  always @(posedge clk_i) begin
    tick <= tick + 1;
    tx_ready_o <= !slow || (tick % 3 == 0);
    if (tx_valid_i && tx_ready_o) begin
      rsp.push_back(tx_data_i);
    end
  end
  function automatic logic [15:0] crc16(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction
  task automatic send(input logic [7:0] f[$], input bit bad, input bit err);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    rsp.delete();
    foreach (f[i]) begin
      @(posedge clk_i);
      rx_data_o <= f[i];
      rx_valid_o <= 1'b1;
      rx_err_o <= err && (i == 2);
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_err_o <= 1'b0;
    // a released line must not keep showing the last byte
    rx_data_o <= ~f[f.size() - 1];
    rx_end_o <= 1'b1;
    @(posedge clk_i);
    rx_end_o <= 1'b0;
  endtask
  task automatic collect();
    int idle;
    idle = 0;
    for (int n = 0; n < 3000 && idle < 80; n++) begin
      @(posedge clk_i);
      idle = tx_valid_i ? 0 : idle + 1;
    end
    crc_ok = rsp.size() == 0 || (rsp.size() > 2 && crc16(rsp) == 16'h0000);
    if (rsp.size() > 2) begin
      rsp = rsp[0:$-2];
    end
  endtask
endmodule
`default_nettype wire

// File: rtu_slave_handler_tb.sv
// self-checking bench for the rtu slave message handler
`timescale 1ns/10ps
`default_nettype none
module rtu_slave_handler_tb import rtu_pkg::*;;
  typedef logic [7:0] rtu_q_t[$];
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] rx_data, tx_data;
  logic rx_valid, rx_err, rx_end, tx_valid, tx_ready, pwe;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  logic [3:0] raddr = 4'h0;
  logic [15:0] rwdata = 16'h0000;
  logic [15:0] pcode, pdata, rrdata;
  logic [79:0] coils = 80'h00f3_5a21_c0de_9b47_8e65;
  logic [31:0] wlog[$];
  int failures = 0;
  int check_count = 0;
  rtu_q_t none;
  rtu_slave_handler i_rtu_slave_handler (
    .CORE_CLK_I(clk), .ARST_N_I(arst_n), .RX_DATA_I(rx_data),
    .RX_VALID_I(rx_valid), .RX_ERR_I(rx_err), .RX_END_I(rx_end),
    .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready),
    .COIL_STATE_I(coils), .PARAM_WE_O(pwe), .PARAM_CODE_O(pcode),
    .PARAM_DATA_O(pdata), .REG_ADDR_I(raddr), .REG_WDATA_I(rwdata),
    .REG_WR_I(rwr), .REG_RD_I(rrd), .REG_RDATA_O(rrdata));
  rtu_host_model i_rtu_host_model (
    .clk_i(clk), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_err_o(rx_err), .rx_end_o(rx_end), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pwe === 1'b1) begin
      wlog.push_back({pcode, pdata});
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  function automatic rtu_q_t echo6(rtu_q_t q);
    return q[0:5];
  endfunction
  function automatic rtu_q_t exc(rtu_q_t q, logic [7:0] c);
    return '{q[0], q[1] | RTU_OP_EXC_FLAG, c};
  endfunction
  task automatic txn(rtu_q_t q, rtu_q_t e, logic [1:0] flt);
    i_rtu_host_model.send(q, flt[0], flt[1]);
    i_rtu_host_model.collect();
    check(i_rtu_host_model.rsp.size(), e.size());
    foreach (e[i]) begin
      check(32'(i_rtu_host_model.rsp[i]), 32'(e[i]));
    end
    check(32'(i_rtu_host_model.crc_ok), 32'h1);
  endtask
  task automatic reg_wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    raddr <= a;
    rwdata <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask
  task automatic reg_rd(logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    raddr <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    // data stand for exactly the cycle after the strobe; take them at its end
    @(posedge clk);
    d = rrdata;
  endtask
  task automatic reg_chk(logic [3:0] a, logic [15:0] e);
    logic [15:0] d;
    reg_rd(a, d);
    check(32'(d), 32'(e));
  endtask
  task automatic t_multi();
    rtu_q_t q;
    int n;
    n = wlog.size();
    q = '{8'h01, 8'h10, 8'h01, 8'h61, 8'h00, 8'h03, 8'h06,
          8'ha1, 8'ha2, 8'hb1, 8'hb2, 8'hc1, 8'hc2};
    txn(q, echo6(q), 2'b00);
    q = '{8'h01, 8'h10, 8'h01, 8'h62, 8'h00, 8'h03, 8'h06,
          8'hd1, 8'hd2, 8'he1, 8'he2, 8'hf1, 8'hf2};
    txn(q, echo6(q), 2'b00);
    check(wlog.size(), n + 5);
    check(wlog[$], 32'h0163_e1e2);
    txn('{8'h01, 8'h03, 8'h01, 8'h61, 8'h00, 8'h04},
        '{8'h01, 8'h03, 8'h08, 8'ha1, 8'ha2, 8'hd1, 8'hd2,
          8'he1, 8'he2, 8'h00, 8'h00}, 2'b00);
    $display("multiple write test done");
  endtask
  task automatic t_read();
    rtu_q_t q, e;
    e = '{8'h01, 8'h03, 8'h64};
    repeat (100) e.push_back(8'h00);
    i_rtu_host_model.slow = 1'b1;
    txn('{8'h01, 8'h03, 8'h01, 8'h64, 8'h00, 8'h32}, e, 2'b00);
    i_rtu_host_model.slow = 1'b0;
    q = '{8'h01, 8'h03, 8'h01, 8'h00, 8'h00, 8'h33};
    txn(q, exc(q, RTU_EXC_BAD_DATA), 2'b00);
    q = '{8'h01, 8'h03, 8'h09, 8'h00, 8'h00, 8'h01};
    txn(q, exc(q, RTU_EXC_BAD_ADDR), 2'b00);
    $display("read limit test done");
  endtask
  task automatic t_groups();
    logic [15:0] pc[7] = '{16'h0863, 16'h0900, 16'h0c00, 16'h0d00,
                           16'h1163, 16'h1200, 16'h0064};
    bit ok[7] = '{1, 0, 0, 1, 1, 0, 0};
    rtu_q_t q;
    foreach (pc[i]) begin
      q = '{8'h01, 8'h06, pc[i][15:8], pc[i][7:0], 8'h3c, 8'(i)};
      if (ok[i]) begin
        txn(q, q, 2'b00);
        check(wlog[$], {pc[i], 8'h3c, 8'(i)});
      end else begin
        txn(q, exc(q, RTU_EXC_BAD_ADDR), 2'b00);
      end
    end
    $display("group code test done");
  endtask
  task automatic t_bcast();
    txn('{8'h00, 8'h03, 8'h01, 8'h00, 8'h00, 8'h01}, none, 2'b00);
    txn('{8'h00, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, none, 2'b00);
    txn('{8'h00, 8'h06, 8'h0d, 8'h05, 8'h5a, 8'h5a}, none, 2'b00);
    txn('{8'h00, 8'h10, 8'h0d, 8'h06, 8'h00, 8'h01, 8'h02, 8'h77, 8'h88},
        none, 2'b00);
    txn('{8'h01, 8'h03, 8'h0d, 8'h05, 8'h00, 8'h02},
        '{8'h01, 8'h03, 8'h04, 8'h5a, 8'h5a, 8'h77, 8'h88},
        2'b00);
    $display("broadcast test done");
  endtask
  task automatic t_count();
    rtu_q_t q;
    q = '{8'h01, 8'h10, 8'h00, 8'h32, 8'h00, 8'h32, 8'h64};
    repeat (100) q.push_back(8'h22);
    txn(q, echo6(q), 2'b00);
    q = '{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h33, 8'h66};
    repeat (102) q.push_back(8'h11);
    txn(q, exc(q, RTU_EXC_BAD_DATA), 2'b00);
    q = '{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h05,
          8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
    txn(q, exc(q, RTU_EXC_BAD_DATA), 2'b00);
    $display("word count test done");
  endtask
  task automatic t_misc();
    rtu_q_t q;
    q = '{8'h01, 8'h08, 8'h00, 8'h00, 8'ha5, 8'h5a};
    txn(q, q, 2'b00);
    q[3] = 8'h01;
    txn(q, exc(q, RTU_EXC_BAD_DATA), 2'b00);
    q = '{8'h01, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01};
    txn(q, exc(q, RTU_EXC_BAD_OP), 2'b00);
    reg_chk(RTU_REG_STATUS, 16'h0001);
    q = '{8'h01, 8'h01, 8'h00, 8'h0d, 8'h00, 8'h09};
    txn(q, '{8'h01, 8'h01, 8'h02, coils[20:13], {7'h00, coils[21]}},
        2'b00);
    $display("diagnostics, op code and coil test done");
  endtask
  task automatic t_drop();
    rtu_q_t q;
    int n;
    n = wlog.size();
    reg_wr(RTU_REG_DROPS, 16'h0000);
    q = '{8'h01, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02};
    txn(q, none, 2'b01);
    txn(q, none, 2'b10);
    q[0] = 8'h05;
    txn(q, none, 2'b00);
    check(wlog.size(), n);
    reg_chk(RTU_REG_DROPS, 16'h0003);
    reg_wr(RTU_REG_CTRL, 16'h0105);
    txn(q, q, 2'b00);
    check(wlog[$], 32'h0001_0002);
    reg_wr(RTU_REG_CTRL, 16'h0005);
    txn(q, none, 2'b00);
    reg_chk(RTU_REG_DROPS, 16'h0004);
    reg_wr(RTU_REG_CTRL, RTU_CTRL_RST);
    $display("discard test done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    reg_chk(RTU_REG_CTRL, RTU_CTRL_RST);
    reg_chk(4'hc, 16'h0000);
    t_multi();
    t_read();
    t_groups();
    t_bcast();
    t_count();
    t_misc();
    t_drop();
    conclude();
  end
  // generous bound: every exchange above ends well inside 600 cycles
  initial begin
    #(25 * 60000);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
